// [design/pcr_clock_reset.v]
// Purpose: Core clock ratio, derived clock enables and core reset release
// Assumes: reference clock and reset pin are asynchronous to aclk
// Notes: Clocks are modelled as one-cycle enables on aclk
`timescale 1ns/1ps
`include "pcr_consts.vh"

// Operation
// [R01] Core rate is 2M times input over 2N
// [R02] Input is reference, halved when divider enabled
// [R03] Peripheral enable every second core tick
// [R04] Serial bit tick divides core by ratio
// [R05] SPI tick divides core by rate register
// [R06] Ratio pins load multiplier during reset
// [R07] Software keeps oscillator frequency in range
// [R08] Software keeps core period in range
// [R09] Core reset held 4096 reference plus 2 core
// [R10] Synchroniser slip adds at most one reference
// [R11] Later resets low at least 4 references
// [R12] Reset held until reference stable 10 us
// [R13] Ratio pins stable 20 us before release
// [R14] Software programs multiplier for full speed
// [R15] Lock flag within 100 us of start
// [R16] Reassertion restarts release counter
module pcr_clock_reset #(
  parameter LOCK_CYCLES = `PCR_LOCK_CYCLES
) (
  input wire aclk, // System clock, 200 MHz
  input wire aresetn, // Synchronous reset, active low
  input wire [3:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output reg s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write byte strobes
  input wire s_axi_wvalid, // Write data valid
  output reg s_axi_wready, // Write data ready
  output reg [1:0] s_axi_bresp, // Write response
  output reg s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [3:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output reg s_axi_arready, // Read address ready
  output reg [31:0] s_axi_rdata, // Read data
  output reg [1:0] s_axi_rresp, // Read response
  output reg s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  input wire reference_clock_input, // Reference clock pin
  input wire reset_pin_n, // External reset pin, active low
  input wire [1:0] ratio_select_pins, // Ratio strap pins
  output reg core_clock_en_q, // Core clock enable
  output wire periph_clock_en_q, // Peripheral clock enable
  output wire serial_bit_en_q, // Serial port bit enable
  output wire spi_bit_clock_en_q, // SPI bit clock enable
  output reg core_reset_n_q, // Core reset, active low
  output reg pll_locked_q // Lock flag
);

  localparam ST_HOLD = 2'b00;
  localparam ST_REF = 2'b01;
  localparam ST_CORE = 2'b10;
  localparam ST_RUN = 2'b11;

  reg ref_s1_q, ref_s2_q, ref_s3_q;
  reg [1:0] rst_s_q;
  reg [1:0] cfg_s1_q, cfg_s2_q;
  reg [6:0] mult_q;
  reg [3:0] div_q;
  reg indiv_q;
  reg [15:0] spdiv_q, spirate_q;
  reg in_phase_q;
  reg [15:0] per_cnt_q, per_q;
  reg [20:0] acc_q;
  reg [31:0] lock_cnt_q;
  reg [1:0] state_q;
  reg [12:0] ref_cnt_q;
  reg [1:0] core_cnt_q;
  reg aw_got_q, w_got_q;
  reg [3:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire ref_edge;
  wire in_edge;
  wire [20:0] thr;
  wire [20:0] acc_sum;
  wire do_write;
  wire [31:0] power_mgmt_control_rd;
  wire [31:0] power_mgmt_control_new;
  wire [31:0] spdiv_new;
  wire [31:0] spirate_new;

  // Byte-lane merge of a write into an old value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Multiplier selected by the ratio pins
  function [6:0] pin_mult;
    input [1:0] cfg;
    begin
      case (cfg)
        2'b00: pin_mult = `PCR_MULT_CFG0;
        2'b01: pin_mult = `PCR_MULT_CFG1;
        2'b10: pin_mult = `PCR_MULT_CFG2;
        default: pin_mult = `PCR_MULT_CFG3;
      endcase
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
      rst_s_q <= 2'b00;
      cfg_s1_q <= 2'b00;
      cfg_s2_q <= 2'b00;
    end else begin
      ref_s1_q <= reference_clock_input;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
      rst_s_q <= {rst_s_q[0], reset_pin_n};
      cfg_s1_q <= ratio_select_pins;
      cfg_s2_q <= cfg_s1_q;
    end
  end

  assign ref_edge = ref_s2_q & ~ref_s3_q;
  assign in_edge = ref_edge & (~indiv_q | in_phase_q); // R02

  // ****************************************
  // Input period measure and rate accumulator
  // ****************************************
  assign thr = {1'b0, div_q} * {5'h00, per_q}; // R01
  assign acc_sum = acc_q + {14'h0000, mult_q};

  always @(posedge aclk) begin
    if (!aresetn) begin
      in_phase_q <= 1'b0;
      per_cnt_q <= 16'h0000;
      per_q <= 16'h0000;
      acc_q <= 21'h000000;
      core_clock_en_q <= 1'b0;
    end else begin
      if (ref_edge) begin
        in_phase_q <= ~in_phase_q;
      end
      if (in_edge) begin
        per_q <= per_cnt_q + 16'h0001;
        per_cnt_q <= 16'h0000;
      end else if (per_cnt_q != 16'hffff) begin
        per_cnt_q <= per_cnt_q + 16'h0001;
      end
      core_clock_en_q <= 1'b0;
      if (!pll_locked_q || thr == 21'h000000) begin
        acc_q <= 21'h000000;
      end else if (acc_sum >= thr) begin
        acc_q <= acc_sum - thr; // R01
        core_clock_en_q <= 1'b1;
      end else begin
        acc_q <= acc_sum;
      end
    end
  end

  // ****************************************
  // Lock timer, restarted by reprogramming
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_q <= 32'h00000000;
      pll_locked_q <= 1'b0;
    end else if (do_write && awaddr_q == `PCR_OFS_POWER_MGMT_CONTROL) begin
      lock_cnt_q <= 32'h00000000;
      pll_locked_q <= 1'b0;
    end else if (lock_cnt_q + 32'h00000001 >= LOCK_CYCLES) begin
      pll_locked_q <= 1'b1; // R15
    end else begin
      lock_cnt_q <= lock_cnt_q + 32'h00000001;
    end
  end

  // ****************************************
  // Core reset release sequencer
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_HOLD;
      ref_cnt_q <= 13'h0000;
      core_cnt_q <= 2'b00;
      core_reset_n_q <= 1'b0;
    end else if (!rst_s_q[1]) begin
      state_q <= ST_HOLD; // R16
      ref_cnt_q <= 13'h0000; // R16
      core_cnt_q <= 2'b00;
      core_reset_n_q <= 1'b0;
    end else begin
      case (state_q)
        ST_HOLD: begin
          state_q <= ST_REF;
        end
        ST_REF: begin
          if (ref_edge) begin
            if (ref_cnt_q + 13'h0001 >= `PCR_REF_HOLD) begin
              state_q <= ST_CORE; // R09 R10
            end
            ref_cnt_q <= ref_cnt_q + 13'h0001;
          end
        end
        ST_CORE: begin
          if (core_clock_en_q) begin
            if (core_cnt_q + 2'b01 >= `PCR_CORE_HOLD) begin
              state_q <= ST_RUN; // R09
              core_reset_n_q <= 1'b1;
            end
            core_cnt_q <= core_cnt_q + 2'b01;
          end
        end
        default: begin
          core_reset_n_q <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Derived clock enables
  // ****************************************
  pcr_rate_div u_periph (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(core_clock_en_q),
    .ratio(`PCR_PERIPH_RATIO), // R03
    .tick_q(periph_clock_en_q)
  );

  pcr_rate_div u_serial (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(core_clock_en_q),
    .ratio(spdiv_q), // R04
    .tick_q(serial_bit_en_q)
  );

  pcr_rate_div u_spi (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_in(core_clock_en_q),
    .ratio(spirate_q), // R05
    .tick_q(spi_bit_clock_en_q)
  );

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign do_write = aw_got_q & w_got_q & ~s_axi_bvalid;
  assign power_mgmt_control_rd = {15'h0000, indiv_q, 4'h0, div_q, 1'b0, mult_q};
  assign power_mgmt_control_new = merge(power_mgmt_control_rd, wdata_q, wstrb_q);
  assign spdiv_new = merge({16'h0000, spdiv_q}, wdata_q, wstrb_q);
  assign spirate_new = merge({16'h0000, spirate_q}, wdata_q, wstrb_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PCR_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          `PCR_OFS_POWER_MGMT_CONTROL, `PCR_OFS_SPDIV, `PCR_OFS_SPIRATE, `PCR_OFS_STATUS: begin
            s_axi_bresp <= `PCR_RESP_OKAY;
          end
          default: begin
            s_axi_bresp <= `PCR_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Control registers and strap capture
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      mult_q <= `PCR_MULT_CFG0;
      div_q <= `PCR_DIV_RST;
      indiv_q <= `PCR_INDIV_RST;
      spdiv_q <= `PCR_SPDIV_RST;
      spirate_q <= `PCR_SPIRATE_RST;
    end else if (!rst_s_q[1]) begin
      mult_q <= pin_mult(cfg_s2_q); // R06
      div_q <= `PCR_DIV_RST;
      indiv_q <= `PCR_INDIV_RST;
    end else if (do_write) begin
      case (awaddr_q)
        `PCR_OFS_POWER_MGMT_CONTROL: begin
          mult_q <= power_mgmt_control_new[`PCR_MULT_MSB:`PCR_MULT_LSB]; // R14
          div_q <= power_mgmt_control_new[`PCR_DIV_MSB:`PCR_DIV_LSB];
          indiv_q <= power_mgmt_control_new[`PCR_INDIV_BIT];
        end
        `PCR_OFS_SPDIV: begin
          spdiv_q <= spdiv_new[15:0];
        end
        `PCR_OFS_SPIRATE: begin
          spirate_q <= spirate_new[15:0];
        end
        default: begin
          spdiv_q <= spdiv_q;
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PCR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `PCR_RESP_OKAY;
      case (s_axi_araddr)
        `PCR_OFS_POWER_MGMT_CONTROL: s_axi_rdata <= power_mgmt_control_rd;
        `PCR_OFS_SPDIV: s_axi_rdata <= {16'h0000, spdiv_q};
        `PCR_OFS_SPIRATE: s_axi_rdata <= {16'h0000, spirate_q};
        `PCR_OFS_STATUS: s_axi_rdata <= {per_q, 12'h000, cfg_s2_q,
                                         core_reset_n_q, pll_locked_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `PCR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [pkg/pcr_consts.vh]
// Purpose: Shared constants of the core clock ratio and reset release block
// Assumes: aclk at 200 MHz, 32-bit AXI4-Lite register access
// Notes: Definitions only
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define PCR_ADDR_W 4
`define PCR_OFS_POWER_MGMT_CONTROL 4'h0
`define PCR_OFS_SPDIV 4'h4
`define PCR_OFS_SPIRATE 4'h8
`define PCR_OFS_STATUS 4'hc

// ****************************************
// Field positions of power_mgmt_control
// ****************************************
`define PCR_MULT_LSB 0
`define PCR_MULT_MSB 6
`define PCR_DIV_LSB 8
`define PCR_DIV_MSB 11
`define PCR_INDIV_BIT 16

// ****************************************
// Reset values
// ****************************************
`define PCR_DIV_RST 4'h1
`define PCR_INDIV_RST 1'b0
`define PCR_SPDIV_RST 16'h0004
`define PCR_SPIRATE_RST 16'h0008

// ****************************************
// Multiplier chosen by the ratio pins
// ****************************************
`define PCR_MULT_CFG0 7'h06
`define PCR_MULT_CFG1 7'h10
`define PCR_MULT_CFG2 7'h08
`define PCR_MULT_CFG3 7'h03

// ****************************************
// Timing
// ****************************************
`define PCR_CLK_MHZ 200
`define PCR_LOCK_TIME_US 100
`define PCR_LOCK_CYCLES (`PCR_LOCK_TIME_US * `PCR_CLK_MHZ)
`define PCR_REF_HOLD 13'h1000
`define PCR_CORE_HOLD 2'h2
`define PCR_PERIPH_RATIO 16'h0002

// ****************************************
// AXI responses
// ****************************************
`define PCR_RESP_OKAY 2'h0
`define PCR_RESP_SLVERR 2'h2

`endif

// [design/pcr_rate_div.v]
// Purpose: Divides a tick stream by a programmable ratio
// Assumes: tick_in is a one-cycle enable on aclk
// Notes: Ratio 0 acts as 1
`timescale 1ns/1ps

module pcr_rate_div (
  input wire aclk, // System clock
  input wire aresetn, // Synchronous reset, active low
  input wire tick_in, // Source enable pulse
  input wire [15:0] ratio, // Source ticks per output tick
  output reg tick_q // Output enable pulse
);

  reg [15:0] cnt_q;

  // ****************************************
  // Tick counter
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (tick_in) begin
        if (cnt_q + 16'h0001 >= ratio) begin
          cnt_q <= 16'h0000;
          tick_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 16'h0001;
        end
      end
    end
  end

endmodule

// [tb/pcr_clock_reset_properties.sv]
// Purpose: Port checks for the clock ratio and reset release block
// Assumes: one aclk domain, reference clock slower than aclk
// Notes: Bound to the design from the bench
`timescale 1ns/1ps

module pcr_clock_reset_properties #(
  parameter LOCK_CYCLES = 50
) (
  input wire aclk, // Clock
  input wire aresetn, // Reset
  input wire s_axi_awvalid, // AW valid
  input wire s_axi_awready, // AW ready
  input wire s_axi_wvalid, // W valid
  input wire s_axi_wready, // W ready
  input wire [1:0] s_axi_bresp, // B code
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire s_axi_arvalid, // AR valid
  input wire s_axi_arready, // AR ready
  input wire [31:0] s_axi_rdata, // R data
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire reference_clock_input, // Ref pin
  input wire reset_pin_n, // Reset pin
  input wire core_clock_en_q, // Core tick
  input wire periph_clock_en_q, // Periph tick
  input wire core_reset_n_q, // Core reset
  input wire pll_locked_q // Lock flag
);
  logic ref_q;
  logic seen_q;
  logic [12:0] ref_cnt_q;
  logic [15:0] unl_q;
  logic [2:0] cc_q;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ********
  // Helper counters
  // ********
  // Ref edges since pin low, unlocked cycles, core ticks per periph tick
  always @(posedge aclk) begin
    ref_q <= reference_clock_input;
    if (!aresetn || !reset_pin_n) ref_cnt_q <= 13'h0000;
    else if (reference_clock_input && !ref_q) ref_cnt_q <= ref_cnt_q + 13'h0001;
    unl_q <= (!aresetn || pll_locked_q) ? 16'h0000 : unl_q + 16'h0001;
    if (!aresetn || !core_reset_n_q) seen_q <= 1'b0;
    else if (periph_clock_en_q) seen_q <= 1'b1;
    if (periph_clock_en_q) cc_q <= {2'b00, core_clock_en_q};
    else cc_q <= cc_q + {2'b00, core_clock_en_q};
  end
  // ********
  // Assertions
  // ********
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stands: assert property (p_r_stands)
    else $error("read data dropped");
  property p_release_count;
    $rose(core_reset_n_q) |-> ref_cnt_q >= 13'h1000 && ref_cnt_q <= 13'h1002;
  endproperty
  a_release_count: assert property (p_release_count)
    else $error("core reset released at wrong count");
  property p_pin_holds;
    !reset_pin_n [*3] |=> !core_reset_n_q;
  endproperty
  a_pin_holds: assert property (p_pin_holds)
    else $error("core reset free during pin reset");
  property p_core_locked;
    core_clock_en_q |-> pll_locked_q || $past(pll_locked_q);
  endproperty
  a_core_locked: assert property (p_core_locked)
    else $error("core tick without lock");
  property p_lock_time;
    !pll_locked_q |-> unl_q <= LOCK_CYCLES + 8;
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("lock too slow");
  property p_periph_half;
    periph_clock_en_q && seen_q |-> cc_q == 3'h2;
  endproperty
  a_periph_half: assert property (p_periph_half)
    else $error("periph tick not every second core tick");
endmodule

// [tb/pcr_ref_source.sv]
// Purpose: Reference oscillator and external reset source
// Assumes: free running 25 MHz reference
// Notes: Release keeps the hold-off and setup times
`timescale 1ns/1ps

module pcr_ref_source #(
  parameter real HALF_NS = 20.0
) (
  output logic ref_clk, // Ref pin
  output logic rst_n, // Reset pin
  output logic [1:0] ratio // Strap pins
);
  realtime cfg_t;
  realtime low_t;
  // Oscillator, reset held from power-up
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    ratio = 2'b00;
    cfg_t = 0.0;
    low_t = 0.0;
    #3.3;
    forever #(HALF_NS) ref_clk = ~ref_clk;
  end
  // Strap change restarts hold-off
  task automatic set_ratio(input logic [1:0] r);
    ratio = r;
    cfg_t = $realtime;
  endtask
  // Pin reset asserted
  task automatic drop_rst;
    rst_n = 1'b0;
    low_t = $realtime;
  endtask
  // Release away from the falling reference edge
  task automatic release_rst;
    while ($realtime < cfg_t + 20000.0 || $realtime < 10000.0) #100;
    while ($realtime < low_t + 8.0 * HALF_NS) #10;
    @(posedge ref_clk);
    #5 rst_n = 1'b1;
  endtask
endmodule

// [tb/pcr_clock_reset_bench.sv]
// Purpose: Self-checking bench for the clock ratio and reset release block
// Assumes: lock time cut to 50 cycles, 25 MHz reference
// Notes: Register checks and a first release, then rate rows, reset cases after
`timescale 1ns/1ps

module pcr_clock_reset_bench;
  typedef struct {
    logic [6:0] m;
    logic [3:0] n;
    logic h;
    logic [15:0] sd;
    logic [15:0] sr;
    int c;
  } pcr_row_t;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic reference_clock_input, reset_pin_n, core_clock_en_q, periph_clock_en_q;
  logic serial_bit_en_q, spi_bit_clock_en_q, core_reset_n_q, pll_locked_q;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, q;
  logic [1:0] s_axi_bresp, s_axi_rresp, ratio_select_pins, r, rs;
  int fails = 0;
  int samples_checked = 0;
  int k;
  int cnt [4];
  // Multiplier, divider, halve, serial and SPI ratios, core ticks per 800
  pcr_row_t rows [4] = '{
    '{7'h06, 4'h1, 1'b0, 16'h0004, 16'h0008, 600},
    '{7'h08, 4'h2, 1'b0, 16'h0000, 16'h0003, 400},
    '{7'h10, 4'h1, 1'b1, 16'h0001, 16'h0010, 800},
    '{7'h0a, 4'h2, 1'b0, 16'h0005, 16'h0002, 500}};
  logic [6:0] pin_m [4] = '{7'h06, 7'h10, 7'h08, 7'h03};

  pcr_clock_reset #(.LOCK_CYCLES(50)) u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reference_clock_input, .reset_pin_n, .ratio_select_pins,
    .core_clock_en_q, .periph_clock_en_q, .serial_bit_en_q, .spi_bit_clock_en_q,
    .core_reset_n_q, .pll_locked_q);
  pcr_ref_source u_src (.ref_clk(reference_clock_input), .rst_n(reset_pin_n),
    .ratio(ratio_select_pins));

  // ********
  // Tasks
  // ********
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic near(input string s, input int e, input int g, input int t);
    samples_checked++;
    if (g < e - t || g > e + t) begin
      fails++;
      $display("mismatch %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic tick(inout int n, input int lim);
    @(posedge aclk);
    n++;
    if (n > lim) begin
      fails++;
      $display("mismatch wait expected done seen timeout");
      tally_and_finish();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] o);
    int n;
    logic aw, w, b;
    n = 0;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || w || b) begin
      tick(n, 100);
      if (!aw && !w && s_axi_bvalid) begin
        if (s_axi_bready) begin
          b = 1'b0;
          o = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end else s_axi_bready <= 1'b1;
      end
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] o);
    int n;
    logic ar, rr;
    n = 0;
    ar = 1'b1;
    rr = 1'b1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (ar || rr) begin
      tick(n, 100);
      if (!ar && s_axi_rvalid) begin
        if (s_axi_rready) begin
          rr = 1'b0;
          o = s_axi_rdata;
          rs = s_axi_rresp;
          s_axi_rready <= 1'b0;
        end else s_axi_rready <= 1'b1;
      end
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask
  task automatic measure(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge aclk);
      cnt[0] += core_clock_en_q;
      cnt[1] += periph_clock_en_q;
      cnt[2] += serial_bit_en_q;
      cnt[3] += spi_bit_clock_en_q;
    end
  endtask
  task automatic release_time;
    int n;
    n = 0;
    u_src.release_rst();
    while (core_reset_n_q !== 1'b1) tick(n, 40000);
    near("release cycles", 32776, n, 8);
  endtask

  // ********
  // Clock and sequence
  // ********
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Reset, register checks, rate rows, reset release cases
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(4'h4, d);
    chk("serial divisor reset", 32'h4, d);
    axr(4'h8, d);
    chk("spi rate reset", 32'h8, d);
    for (int i = 0; i < 4; i++) begin
      u_src.set_ratio(2'(i));
      repeat (8) @(posedge aclk);
      axr(4'h0, d);
      chk("strap multiplier", {24'h000001, 1'b0, pin_m[i]}, d);
    end
    k = 0;
    while (pll_locked_q !== 1'b1) tick(k, 1000);
    axw(4'hc, 32'hffffffff, r);
    chk("status write resp", 32'h0, {30'h0, r});
    axr(4'hc, d);
    chk("status", {16'h0008, 12'h000, 2'b11, 1'b0, 1'b1}, d);
    chk("status read resp", 32'h0, {30'h0, rs});
    // Unmapped offset answers with an error and changes nothing
    axw(4'h2, 32'h0000ffff, r);
    chk("unmapped write resp", 32'h2, {30'h0, r});
    axr(4'h2, d);
    chk("unmapped read data", 32'h0, d);
    chk("unmapped read resp", 32'h2, {30'h0, rs});
    axr(4'h4, d);
    chk("serial divisor kept", 32'h4, d);
    u_src.set_ratio(2'b00);
    release_time();
    // Software rows keep oscillator and core period in range
    foreach (rows[i]) begin
      axw(4'h4, {16'h0000, rows[i].sd}, r);
      axw(4'h8, {16'h0000, rows[i].sr}, r);
      d = {15'h0000, rows[i].h, 4'h0, rows[i].n, 1'b0, rows[i].m};
      axw(4'h0, d, r);
      chk("power_mgmt_control write resp", 32'h0, {30'h0, r});
      k = 0;
      while (pll_locked_q !== 1'b1) tick(k, 1000);
      repeat (64) @(posedge aclk);
      measure(800);
      near("core ticks", rows[i].c, cnt[0], 2);
      near("periph ticks", rows[i].c / 2, cnt[1], 2);
      near("serial ticks", rows[i].c / (rows[i].sd ? rows[i].sd : 1), cnt[2], 2);
      near("spi ticks", rows[i].c / rows[i].sr, cnt[3], 2);
      axr(4'h0, q);
      chk("power_mgmt_control readback", d, q);
    end
    u_src.drop_rst();
    u_src.release_rst();
    repeat (2000) @(posedge aclk);
    chk("core reset mid count", 32'h0, {31'h0, core_reset_n_q});
    u_src.drop_rst();
    release_time();
    tally_and_finish();
  end
endmodule

bind pcr_clock_reset pcr_clock_reset_properties #(.LOCK_CYCLES(LOCK_CYCLES)) u_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .reference_clock_input, .reset_pin_n, .core_clock_en_q,
  .periph_clock_en_q, .core_reset_n_q, .pll_locked_q);
